/* File: src/fsp_pkg.sv */
// Package: pin groups, request encodings and strobe timing for the shared bus host
package fsp_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;
  // Strobe phase lengths in ns (plain defaults, no figure printed)
  localparam int unsigned SETUP_NS  = 20;
  localparam int unsigned STROBE_NS = 70;
  localparam int unsigned HOLD_NS   = 20;
  localparam int unsigned SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] SETUP_CNT  = CNT_W'(SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_CNT   = CNT_W'(HOLD_CYC - 1);

  // Address widths per density
  localparam int unsigned ADDR_W      = 21;
  localparam int unsigned ADDR_W_2M   = 17;
  localparam int unsigned ADDR_W_4M   = 19;
  localparam int unsigned ADDR_W_16M  = 20;
  localparam int unsigned ADDR_W_32M  = 21;
  localparam int unsigned DATA_W      = 16;

  typedef enum logic [1:0] {
    FSP_DEN_2M,
    FSP_DEN_4M,
    FSP_DEN_16M,
    FSP_DEN_32M
  } fsp_density_t;

  typedef enum logic [1:0] {
    FSP_OP_FLASH_READ,
    FSP_OP_FLASH_WRITE,
    FSP_OP_SRAM_READ,
    FSP_OP_SRAM_WRITE
  } fsp_op_t;

  typedef struct packed {
    fsp_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic [1:0]          byte_en;
  } fsp_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq_out;
    logic                dq_oe_n;
    logic                flash_ce_n;
    logic                flash_oe_n;
    logic                flash_we_n;
    logic                flash_reset_powerdown_n;
    logic                flash_wp_n;
    logic                sram_select_low_n;
    logic                sram_select_high;
    logic                sram_oe_n;
    logic                sram_we_n;
    logic                sram_high_byte_n;
    logic                sram_low_byte_n;
  } fsp_pins_t;

  localparam logic [ADDR_W-1:0] ADDR_ZERO = 21'h000000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

endpackage : fsp_pkg

/* File: src/fsp_addr_mask.sv */
// Address masking by array density
`timescale 1ns/100ps
module fsp_addr_mask (
  input  wire  fsp_pkg::fsp_density_t              density,
  input  wire  logic [fsp_pkg::ADDR_W-1:0]         addr_in,
  output logic [fsp_pkg::ADDR_W-1:0]               addr_out
);
  import fsp_pkg::*;

  logic [ADDR_W-1:0] mask;

  always_comb
  begin
    unique case (density)
      FSP_DEN_2M:  mask = ADDR_W'((1 << ADDR_W_2M) - 1);
      FSP_DEN_4M:  mask = ADDR_W'((1 << ADDR_W_4M) - 1);
      FSP_DEN_16M: mask = ADDR_W'((1 << ADDR_W_16M) - 1);
      FSP_DEN_32M: mask = ADDR_W'((1 << ADDR_W_32M) - 1);
    endcase
  end

  assign addr_out = addr_in & mask;

endmodule : fsp_addr_mask

/* File: src/fsp_host.sv */
// Host controller for the shared flash and SRAM parallel bus
//
// Operation
// - Only density-appropriate address lines carry address: 17, 19, 20 or 21.
// - Host puts program data on the bus in the second flash write cycle.
// - Commands travel on the 16-bit data bus with flash enable and write low.
// - Flash output enable active low; flash drives bus only then.
// - SRAM output enable active low; SRAM drives bus only then.
// - SRAM write enable and the byte lane enables together decide whether an SRAM cycle writes.
`timescale 1ns/100ps
module fsp_host (
  input  wire  logic                          clk,
  input  wire  logic                          reset,
  input  wire  fsp_pkg::fsp_density_t         density,
  input  wire  logic                          flash_reset_req,
  input  wire  logic                          lockdown_enable,
  input  wire  logic                          req_valid,
  output logic                                req_ready,
  input  wire  fsp_pkg::fsp_req_t             req,
  output logic                                rsp_valid,
  output logic [fsp_pkg::DATA_W-1:0]          rsp_data,
  output fsp_pkg::fsp_pins_t                  pins,
  input  wire  logic [fsp_pkg::DATA_W-1:0]    dq_in
);
  import fsp_pkg::*;

  typedef enum logic [1:0] {
    FSP_IDLE,
    FSP_SETUP,
    FSP_STROBE,
    FSP_HOLD
  } fsp_state_t;

  typedef struct packed {
    fsp_state_t          state;
    logic [CNT_W-1:0]    cnt;
    fsp_op_t             op;
    logic [1:0]          byte_en;
    fsp_pins_t           pins;
    logic                rsp_valid;
    logic [DATA_W-1:0]   rsp_data;
  } fsp_host_state_t;

  localparam fsp_pins_t PINS_IDLE = '{
    addr:                    ADDR_ZERO,
    dq_out:                  DATA_ZERO,
    dq_oe_n:                 1'b1,
    flash_ce_n:              1'b1,
    flash_oe_n:              1'b1,
    flash_we_n:              1'b1,
    flash_reset_powerdown_n: 1'b0,
    flash_wp_n:              1'b0,
    sram_select_low_n:       1'b1,
    sram_select_high:        1'b0,
    sram_oe_n:               1'b1,
    sram_we_n:               1'b1,
    sram_high_byte_n:        1'b1,
    sram_low_byte_n:         1'b1
  };

  localparam fsp_host_state_t ST_RESET = '{
    state:     FSP_IDLE,
    cnt:       '0,
    op:        FSP_OP_FLASH_READ,
    byte_en:   2'h0,
    pins:      PINS_IDLE,
    rsp_valid: 1'b0,
    rsp_data:  DATA_ZERO
  };

  fsp_host_state_t   st;
  fsp_host_state_t   next_st;
  logic [ADDR_W-1:0] masked_addr;
  logic              is_flash;
  logic              is_write;

  fsp_addr_mask u_mask (
    .density  (density),
    .addr_in  (req.addr),
    .addr_out (masked_addr)
  );

  assign is_flash  = (req.op == FSP_OP_FLASH_READ) || (req.op == FSP_OP_FLASH_WRITE);
  assign is_write  = (req.op == FSP_OP_FLASH_WRITE) || (req.op == FSP_OP_SRAM_WRITE);
  assign req_ready = (st.state == FSP_IDLE) && !flash_reset_req;
  assign rsp_valid = st.rsp_valid;
  assign rsp_data  = st.rsp_data;
  assign pins      = st.pins;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st           = st;
    next_st.rsp_valid = 1'b0;
    next_st.pins.flash_reset_powerdown_n = !flash_reset_req;
    next_st.pins.flash_wp_n              = !lockdown_enable;
    unique case (st.state)
      FSP_IDLE:
      begin
        if (req_valid && req_ready)
        begin
          next_st.state        = FSP_SETUP;
          next_st.cnt          = SETUP_CNT;
          next_st.op           = req.op;
          next_st.byte_en      = req.byte_en;
          next_st.pins.addr    = masked_addr;
          next_st.pins.dq_out  = req.wdata;
          next_st.pins.dq_oe_n = !is_write;
          next_st.pins.flash_ce_n        = !is_flash;
          next_st.pins.sram_select_low_n = is_flash;
          next_st.pins.sram_select_high  = !is_flash;
          next_st.pins.sram_high_byte_n  = is_flash || !req.byte_en[1];
          next_st.pins.sram_low_byte_n   = is_flash || !req.byte_en[0];
        end
      end
      FSP_SETUP:
      begin
        if (st.cnt != '0)
          next_st.cnt = st.cnt - 1'b1;
        else
        begin
          next_st.state = FSP_STROBE;
          next_st.cnt   = STROBE_CNT;
          // Only one output enable per cycle
          unique case (st.op)
            FSP_OP_FLASH_READ:  next_st.pins.flash_oe_n = 1'b0;
            FSP_OP_FLASH_WRITE: next_st.pins.flash_we_n = 1'b0;
            FSP_OP_SRAM_READ:   next_st.pins.sram_oe_n  = 1'b0;
            FSP_OP_SRAM_WRITE:  next_st.pins.sram_we_n  = 1'b0;
          endcase
        end
      end
      FSP_STROBE:
      begin
        if (st.cnt != '0)
          next_st.cnt = st.cnt - 1'b1;
        else
        begin
          next_st.state = FSP_HOLD;
          next_st.cnt   = HOLD_CNT;
          if (!st.pins.flash_oe_n || !st.pins.sram_oe_n)
          begin
            next_st.rsp_valid = 1'b1;
            next_st.rsp_data  = dq_in;
          end
          // Rising write edge latches address and data in the die
          next_st.pins.flash_oe_n = 1'b1;
          next_st.pins.sram_oe_n  = 1'b1;
          next_st.pins.flash_we_n = 1'b1;
          next_st.pins.sram_we_n  = 1'b1;
        end
      end
      FSP_HOLD:
      begin
        if (st.cnt != '0)
          next_st.cnt = st.cnt - 1'b1;
        else
        begin
          // Bus, die selects and byte lanes released; address lines keep their value
          next_st.state = FSP_IDLE;
          next_st.pins.dq_oe_n           = 1'b1;
          next_st.pins.flash_ce_n        = 1'b1;
          next_st.pins.sram_select_low_n = 1'b1;
          next_st.pins.sram_select_high  = 1'b0;
          next_st.pins.sram_high_byte_n  = 1'b1;
          next_st.pins.sram_low_byte_n   = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st <= ST_RESET;
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_oe_exclusive: assert property (@(posedge clk) disable iff (reset)
    !(!st.pins.flash_oe_n && !st.pins.sram_oe_n))
    else $error("both output enables low");

  a_no_drive_read: assert property (@(posedge clk) disable iff (reset)
    (!st.pins.flash_oe_n || !st.pins.sram_oe_n) |-> st.pins.dq_oe_n)
    else $error("host drives bus during read");

  a_flash_we_sel: assert property (@(posedge clk) disable iff (reset)
    !st.pins.flash_we_n |-> (!st.pins.flash_ce_n && !st.pins.dq_oe_n))
    else $error("flash write without select or data");

  a_sram_sel_pair: assert property (@(posedge clk) disable iff (reset)
    st.pins.sram_select_high == !st.pins.sram_select_low_n)
    else $error("sram selects disagree");

  a_one_die: assert property (@(posedge clk) disable iff (reset)
    !st.pins.flash_ce_n |-> !st.pins.sram_select_high)
    else $error("both dies selected");

  a_sram_we_sel: assert property (@(posedge clk) disable iff (reset)
    !st.pins.sram_we_n |-> (st.pins.sram_select_high && !st.pins.dq_oe_n))
    else $error("sram write without select");

  a_we_width: assert property (@(posedge clk) disable iff (reset)
    $fell(st.pins.flash_we_n) |-> !st.pins.flash_we_n [*8])
    else $error("flash write pulse too short");

  a_read_rsp: assert property (@(posedge clk) disable iff (reset)
    ($rose(st.pins.flash_oe_n) || $rose(st.pins.sram_oe_n)) |-> st.rsp_valid)
    else $error("read without response");

  a_reset_pin: assert property (@(posedge clk) disable iff (reset)
    flash_reset_req |=> !st.pins.flash_reset_powerdown_n)
    else $error("flash reset pin not low");

  a_wp_pin: assert property (@(posedge clk) disable iff (reset)
    lockdown_enable |=> !st.pins.flash_wp_n)
    else $error("write protect not low");

  a_byte_gate: assert property (@(posedge clk) disable iff (reset)
    !st.pins.flash_ce_n |-> (st.pins.sram_high_byte_n && st.pins.sram_low_byte_n))
    else $error("byte enables on flash cycle");

endmodule : fsp_host

/* File: dv/fsp_dev_model.sv */
// Behavioural model of the flash and SRAM dies on the shared bus
`timescale 1ns/100ps
module fsp_dev_model
  import fsp_pkg::*;
(
  input  wire  logic        clk,
  input  wire  fsp_pins_t   pins,
  output logic [15:0]       dq_level,
  output logic              clash
);
  logic [15:0] flash_mem [256];
  logic [15:0] sram_mem  [256];
  logic [15:0] last = 16'h0000;
  logic        prev_fwe = 1'b1;
  logic        prev_swe = 1'b1;
  logic        second = 1'b0;
  logic [15:0] lane;
  logic [15:0] drv;
  logic [7:0]  a;
  logic        f_rd;
  logic        s_sel;
  logic        s_rd;

  assign a     = pins.addr[7:0];
  assign s_sel = !pins.sram_select_low_n && pins.sram_select_high;
  assign f_rd  = !pins.flash_ce_n && !pins.flash_oe_n && pins.flash_reset_powerdown_n;
  assign s_rd  = s_sel && !pins.sram_oe_n;
  assign clash = (!pins.dq_oe_n && (f_rd || s_rd)) || (f_rd && s_rd);

  ////////////////////////////////////////////////////////////////////////////
  // Released lanes show the inverse of the last level
  always_comb
  begin
    lane = {{8{!pins.sram_high_byte_n}}, {8{!pins.sram_low_byte_n}}};
    drv  = ~last;
    if (f_rd)
      drv = flash_mem[a];
    if (s_rd)
      drv = (sram_mem[a] & lane) | (~last & ~lane);
    dq_level = !pins.dq_oe_n ? pins.dq_out : drv;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writes land on the rising write strobe
  always @(posedge clk)
  begin
    last     <= dq_level;
    prev_fwe <= pins.flash_we_n;
    prev_swe <= pins.sram_we_n;
    if (!pins.flash_reset_powerdown_n)
      second <= 1'b0;
    else if (!pins.flash_ce_n && pins.flash_we_n && !prev_fwe)
    begin
      if (second)
        flash_mem[a] <= dq_level;
      second <= !second;
    end
    if (s_sel && pins.sram_we_n && !prev_swe)
    begin
      if (!pins.sram_high_byte_n)
        sram_mem[a][15:8] <= dq_level[15:8];
      if (!pins.sram_low_byte_n)
        sram_mem[a][7:0] <= dq_level[7:0];
    end
  end
endmodule : fsp_dev_model

/* File: dv/tb_top.sv */
// Self-checking testbench for the shared bus host
`timescale 1ns/100ps
module tb_top;
  import fsp_pkg::*;
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  fsp_density_t density = FSP_DEN_32M;
  logic         flash_reset_req = 1'b0;
  logic         lockdown_enable = 1'b0;
  logic         req_valid = 1'b0;
  logic         req_ready;
  fsp_req_t     req = '0;
  logic         rsp_valid;
  logic [15:0]  rsp_data;
  fsp_pins_t    pins;
  logic [15:0]  dq_level;
  logic         clash;
  logic [15:0]  q;
  int           n_fail = 0;
  int           n_checks = 0;

  always #2 clk = ~clk;

  fsp_host fsp_host_inst (.clk(clk), .reset(reset), .density(density),
    .flash_reset_req(flash_reset_req), .lockdown_enable(lockdown_enable),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .pins(pins), .dq_in(dq_level));
  fsp_dev_model fsp_dev_model_inst (.clk(clk), .pins(pins), .dq_level(dq_level),
    .clash(clash));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic xfer(input fsp_op_t op, input logic [20:0] ad, input logic [15:0] d,
                      input logic [1:0] be);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{op: op, addr: ad, wdata: d, byte_en: be};
    do
    begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    req_valid <= 1'b0;
    if (n >= 100)
      chk(1'b0, 1'b1, "request not taken");
  endtask : xfer

  task automatic rd_rsp(output logic [15:0] d);
    int n;
    for (n = 0; n < 40 && rsp_valid !== 1'b1; n++)
      @(negedge clk);
    chk(rsp_valid, 1'b1, "no read answer");
    d = rsp_data;
  endtask : rd_rsp

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_sram;
    xfer(FSP_OP_SRAM_WRITE, 21'h000012, 16'hA5C3, 2'h3);
    xfer(FSP_OP_SRAM_WRITE, 21'h000012, 16'h7E00, 2'h2);
    xfer(FSP_OP_SRAM_READ, 21'h000012, 16'h0000, 2'h3);
    rd_rsp(q);
    chk(q, 16'h7EC3, "sram lanes");
    xfer(FSP_OP_SRAM_READ, 21'h000012, 16'h0000, 2'h1);
    rd_rsp(q);
    chk({8'h00, q[7:0]}, 16'h00C3, "sram low lane");
    $display("test sram done");
  endtask : t_sram

  task automatic t_flash;
    xfer(FSP_OP_FLASH_WRITE, 21'h000034, 16'h0040, 2'h0);
    xfer(FSP_OP_FLASH_WRITE, 21'h000034, 16'h1234, 2'h0);
    xfer(FSP_OP_FLASH_READ, 21'h000034, 16'h0000, 2'h0);
    rd_rsp(q);
    chk(q, 16'h1234, "flash program");
    $display("test flash done");
  endtask : t_flash

  task automatic t_density;
    int w [4] = '{ADDR_W_2M, ADDR_W_4M, ADDR_W_16M, ADDR_W_32M};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      density <= fsp_density_t'(i);
      xfer(FSP_OP_FLASH_READ, 21'h1FFFFF, 16'h0000, 2'h0);
      @(negedge clk);
      @(negedge clk);
      chk(pins.addr[20:5], 16'(21'h1FFFFF >> (21 - w[i]) >> 5), "addr mask");
      chk(pins.dq_oe_n, 1'b1, "host drives on read");
      rd_rsp(q);
    end
    $display("test density done");
  endtask : t_density

  // Reset in the middle of an SRAM write strobe
  task automatic t_reset;
    xfer(FSP_OP_SRAM_WRITE, 21'h000020, 16'h5A5A, 2'h3);
    repeat (10) @(posedge clk);
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk(pins.sram_we_n, 1'b1, "write strobe after reset");
    chk(pins.dq_oe_n, 1'b1, "bus driven after reset");
    chk(pins.sram_select_low_n, 1'b1, "select after reset");
    chk(pins.flash_reset_powerdown_n, 1'b0, "reset pin at release");
    chk(req_ready, 1'b1, "ready after reset");
    @(negedge clk);
    chk(pins.flash_reset_powerdown_n, 1'b1, "reset pin follows");
    xfer(FSP_OP_SRAM_READ, 21'h000012, 16'h0000, 2'h3);
    rd_rsp(q);
    chk(q, 16'h7EC3, "sram after reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_pins;
    @(posedge clk);
    flash_reset_req <= 1'b1;
    lockdown_enable <= 1'b1;
    repeat (2) @(negedge clk);
    chk(pins.flash_reset_powerdown_n, 1'b0, "reset pin");
    chk(req_ready, 1'b0, "ready in reset");
    chk(pins.flash_wp_n, 1'b0, "wp pin");
    @(posedge clk);
    flash_reset_req <= 1'b0;
    lockdown_enable <= 1'b0;
    repeat (2) @(negedge clk);
    chk(pins.flash_reset_powerdown_n, 1'b1, "reset pin off");
    chk(pins.flash_wp_n, 1'b1, "wp pin off");
    $display("test pins done");
  endtask : t_pins

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk)
    if (clash === 1'b1)
      chk(1'b1, 1'b0, "bus contention");

  initial
  begin
    #40000;
    n_fail++;
    finish_test;
  end

  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_sram;
    t_flash;
    t_density;
    t_reset;
    t_pins;
    finish_test;
  end
endmodule : tb_top
